// [src/clk_ctl_pkg.sv]
package clk_ctl_pkg;

   // Software-visible control bits, one field per control
   typedef struct packed {
      logic sel_fast; // System clock source, 1 selects the fast oscillator
      logic fast_osc_on; // Fast oscillator on/off request
      logic slow_osc_on; // Slow oscillator on/off request
   } clk_ctl_t;

   // Oscillator and standby status
   typedef struct packed {
      logic fast_run; // Fast oscillator enabled
      logic slow_run; // Slow oscillator enabled
      logic standby; // Sleep standby in progress
   } osc_stat_t;

   // Source encoding for the selector
   localparam logic SRC_FAST = 1'h1;
   localparam logic SRC_SLOW = 1'h0;

   // Values after reset: fast source, both oscillators on
   localparam clk_ctl_t CTL_RESET = '{sel_fast: 1'h1, fast_osc_on: 1'h1, slow_osc_on: 1'h1};
   localparam osc_stat_t STAT_RESET = '{fast_run: 1'h1, slow_run: 1'h1, standby: 1'h0};

endpackage : clk_ctl_pkg

// [src/clk_glitchless_sel.sv]
`timescale 1ns/100ps
// Switches between two oscillator tick streams without short periods
module clk_glitchless_sel (
   // Clock and reset
   input wire logic clock_i,
   input wire logic rst_n_i,
   // Source ticks, one pulse per oscillator period
   input wire logic fast_tick_i,
   input wire logic slow_tick_i,
   // Requested source
   input wire logic sel_req_i,
   // Selected tick and source actually in use
   output logic tick_o,
   output logic sel_cur_o
);
   import clk_ctl_pkg::*;

   typedef enum logic [0:0] {PASS, PARK} sel_state_t;

   sel_state_t state_reg; // Changeover state
   logic tick_reg; // Registered output tick
   logic cur_reg; // Source in use
   logic old_tick; // Tick of the source in use
   logic new_tick; // Tick of the requested source

   assign old_tick = (cur_reg == SRC_FAST) ? fast_tick_i : slow_tick_i;
   assign new_tick = (sel_req_i == SRC_FAST) ? fast_tick_i : slow_tick_i;
   assign tick_o = tick_reg;
   assign sel_cur_o = cur_reg;

   // Changeover: finish the old period, then wait for a new period start
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_reg <= PASS;
         cur_reg <= SRC_FAST;
         tick_reg <= 1'h0;
      end else begin
         case (state_reg)
            PASS: begin
               tick_reg <= old_tick;
               // Leave only at the end of a whole old period
               if (sel_req_i != cur_reg && old_tick) begin
                  state_reg <= PARK;
               end
            end
            PARK: begin
               // Nothing passes while parked, so no runt period escapes
               tick_reg <= 1'h0;
               if (sel_req_i == cur_reg) begin
                  state_reg <= PASS;
               end else if (new_tick) begin
                  cur_reg <= sel_req_i;
                  tick_reg <= 1'h1;
                  state_reg <= PASS;
               end
            end
            default: begin
               state_reg <= PASS;
               tick_reg <= 1'h0;
            end
         endcase
      end
   end

   // The source only changes together with a tick of the new source
   switch_on_tick_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      $changed(cur_reg) |-> tick_reg && $past(state_reg) == PARK)
      else $error("source changed without a clean tick");

   // While parked no tick leaves the selector
   park_silent_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      (state_reg == PARK && !(sel_req_i != cur_reg && new_tick)) |=> !tick_reg)
      else $error("tick leaked during changeover");

endmodule : clk_glitchless_sel

// [src/twin_oscillator_clock_control.sv]
`timescale 1ns/100ps
// Summary of operation
// - Reset selects the fast oscillator as system clock
// - Software bit starts or stops fast oscillator
// - Selected fast oscillator cannot be stopped
// - Sleep instruction stops the fast oscillator
// - Slow oscillator always feeds clock and watchdog timers
// - Software bit starts or stops slow oscillator
// - Enabled watchdog keeps slow oscillator running
// - Sleep instruction also stops the slow oscillator
// - Software selects slow or fast system clock
// - CPU may run before slow oscillator settles
// - Standby exit resumes the previous clock state
module twin_oscillator_clock_control (
   // Clock and reset
   input wire logic clock_i,
   input wire logic rst_n_i,
   // Software control writes
   input wire logic fast_osc_on_we_i,
   input wire logic fast_osc_on_i,
   input wire logic slow_osc_on_we_i,
   input wire logic slow_osc_on_i,
   input wire logic sys_sel_we_i,
   input wire logic sys_sel_fast_i,
   // Standby and watchdog
   input wire logic sleep_instruction_i,
   input wire logic wake_i,
   input wire logic wdt_enable_i,
   // Oscillator ticks, one pulse per oscillator period
   input wire logic fast_osc_tick_i,
   input wire logic slow_osc_tick_i,
   // Control readback
   output clk_ctl_pkg::clk_ctl_t ctl_o,
   // Oscillator enables and standby
   output clk_ctl_pkg::osc_stat_t stat_o,
   // Clock outputs
   output logic sys_tick_o,
   output logic sys_fast_o,
   output logic timer_tick_o
);
   import clk_ctl_pkg::*;

   clk_ctl_t ctl_reg; // Stored control bits
   logic standby_reg; // Sleep standby
   logic fast_run_reg; // Fast oscillator enable
   logic slow_run_reg; // Slow oscillator enable
   logic timer_tick_reg; // Slow tick towards the timers
   logic fast_lock; // Fast oscillator must stay on
   logic slow_lock; // Slow oscillator must stay on
   logic fast_run_next;
   logic slow_run_next;
   logic sel_cur; // Source actually feeding the CPU
   logic sys_tick; // Selected tick from the changeover logic
   logic seen_reg; // Helper: a cycle has passed since reset

   // Locks: the source in use, the requested source, and the watchdog's source
   assign fast_lock = (sel_cur == SRC_FAST) || ctl_reg.sel_fast;
   assign slow_lock = wdt_enable_i || (sel_cur == SRC_SLOW) || !ctl_reg.sel_fast;

   // Control register writes; a stop request on a locked oscillator is dropped
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ctl_reg <= CTL_RESET;
      end else begin
         if (fast_osc_on_we_i && (fast_osc_on_i || !fast_lock)) begin
            ctl_reg.fast_osc_on <= fast_osc_on_i;
         end
         if (slow_osc_on_we_i && (slow_osc_on_i || !slow_lock)) begin
            ctl_reg.slow_osc_on <= slow_osc_on_i;
         end
         if (sys_sel_we_i) begin
            ctl_reg.sel_fast <= sys_sel_fast_i;
         end
      end
   end

   // Standby: sleep wins over a simultaneous wake so the sleep is not lost
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         standby_reg <= STAT_RESET.standby;
      end else if (sleep_instruction_i) begin
         standby_reg <= 1'h1;
      end else if (wake_i) begin
         // Control bits are untouched in standby, so the old state returns
         standby_reg <= 1'h0;
      end
   end

   // Oscillator enables; sleep stops both regardless of locks
   always_comb begin
      fast_run_next = (ctl_reg.fast_osc_on || fast_lock) && !sleep_instruction_i;
      slow_run_next = (ctl_reg.slow_osc_on || slow_lock) && !sleep_instruction_i;
      if (standby_reg && !wake_i) begin
         fast_run_next = 1'h0;
         slow_run_next = 1'h0;
      end
   end

   // Registered enables keep the oscillator pins free of decode glitches
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         fast_run_reg <= STAT_RESET.fast_run;
         slow_run_reg <= STAT_RESET.slow_run;
      end else begin
         fast_run_reg <= fast_run_next;
         slow_run_reg <= slow_run_next;
      end
   end

   // Timers always take the slow oscillator, whatever feeds the CPU
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         timer_tick_reg <= 1'h0;
      end else begin
         timer_tick_reg <= slow_osc_tick_i && slow_run_reg;
      end
   end

   // System clock changeover; no wait on slow settling, the CPU may run first
   clk_glitchless_sel sel_u (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .fast_tick_i(fast_osc_tick_i && fast_run_reg),
      .slow_tick_i(slow_osc_tick_i && slow_run_reg),
      .sel_req_i(ctl_reg.sel_fast),
      .tick_o(sys_tick),
      .sel_cur_o(sel_cur)
   );

   // Readback shows locked oscillators as on
   always_comb begin
      ctl_o.sel_fast = ctl_reg.sel_fast;
      ctl_o.fast_osc_on = ctl_reg.fast_osc_on || fast_lock;
      ctl_o.slow_osc_on = ctl_reg.slow_osc_on || slow_lock;
   end

   // Status as one word so the struct port has a single driver
   assign stat_o = '{fast_run: fast_run_reg, slow_run: slow_run_reg, standby: standby_reg};
   // Clock outputs straight from the selector and timer registers
   assign sys_tick_o = sys_tick;
   assign sys_fast_o = sel_cur;
   assign timer_tick_o = timer_tick_reg;

   // Helper for the reset check
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         seen_reg <= 1'h0;
      end else begin
         seen_reg <= 1'h1;
      end
   end

   // First cycle after reset runs from the fast oscillator
   reset_fast_src_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      !seen_reg |-> ctl_reg.sel_fast && sel_cur == SRC_FAST && fast_run_reg)
      else $error("reset did not select the fast oscillator");

   // An unlocked stop request lands in the control bit
   fast_write_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      (fast_osc_on_we_i && !fast_osc_on_i && !fast_lock) |=> !ctl_reg.fast_osc_on)
      else $error("fast oscillator stop request lost");

   // Fast source in use keeps running outside standby
   fast_in_use_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      (sel_cur == SRC_FAST && !standby_reg && !sleep_instruction_i) |=> fast_run_reg || standby_reg)
      else $error("fast oscillator stopped while in use");

   // Sleep beats every lock, both enables drop at once
   sleep_stops_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      sleep_instruction_i |=> !fast_run_reg && !slow_run_reg && standby_reg)
      else $error("sleep did not stop oscillators");

   // Every running slow tick reaches the timers one cycle later
   timer_feed_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      (slow_osc_tick_i && slow_run_reg) |=> timer_tick_o)
      else $error("timer tick missing");

   // Start requests on the slow oscillator are never refused
   slow_write_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      (slow_osc_on_we_i && slow_osc_on_i) |=> ctl_reg.slow_osc_on)
      else $error("slow oscillator start request lost");

   // Watchdog enable holds the slow oscillator on outside standby
   wdt_keeps_slow_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      (wdt_enable_i && !standby_reg && !sleep_instruction_i) |=> slow_run_reg || standby_reg)
      else $error("slow oscillator stopped under watchdog");

   // Refused stop leaves the bit alone and reads back on
   locked_readback_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      (fast_osc_on_we_i && !fast_osc_on_i && fast_lock) |=> $stable(ctl_reg.fast_osc_on)
      && ctl_o.fast_osc_on)
      else $error("locked oscillator write not ignored");

   // Wake rebuilds the enables from untouched control bits
   resume_state_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      (standby_reg && wake_i && !sleep_instruction_i) |=> !standby_reg
      && fast_run_reg == (ctl_reg.fast_osc_on || fast_lock)
      && slow_run_reg == (ctl_reg.slow_osc_on || slow_lock))
      else $error("standby exit did not resume prior state");

   // Start requests are always taken, nothing locks an oscillator off
   fast_start_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      (fast_osc_on_we_i && fast_osc_on_i) |=> ctl_reg.fast_osc_on)
      else $error("fast oscillator start request lost");

   // In standby with no wake both oscillators stay stopped
   standby_off_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      (standby_reg && !wake_i) |=> !fast_run_reg && !slow_run_reg)
      else $error("oscillator ran during standby");

   // Source select write lands in the control bits
   select_write_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      sys_sel_we_i |=> ctl_reg.sel_fast == $past(sys_sel_fast_i))
      else $error("source select write lost");

   // Timer ticks only come from a running slow oscillator
   timer_masked_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      !(slow_osc_tick_i && slow_run_reg) |=> !timer_tick_o)
      else $error("timer tick without running slow oscillator");

endmodule : twin_oscillator_clock_control

// [tb/twin_oscillator_clock_control_tb.sv]
`timescale 1ns/100ps
module twin_oscillator_clock_control_tb;
   import clk_ctl_pkg::*;
   // Inputs, all driven from time zero
   logic clock_i = 1'h0;
   logic rst_n_i = 1'h0;
   logic fast_osc_on_we_i = 1'h0;
   logic fast_osc_on_i = 1'h0;
   logic slow_osc_on_we_i = 1'h0;
   logic slow_osc_on_i = 1'h0;
   logic sys_sel_we_i = 1'h0;
   logic sys_sel_fast_i = 1'h0;
   logic sleep_instruction_i = 1'h0;
   logic wake_i = 1'h0;
   logic wdt_enable_i = 1'h0;
   logic fast_osc_tick_i = 1'h0;
   logic slow_osc_tick_i = 1'h0;
   // Observed outputs
   clk_ctl_t ctl_o;
   osc_stat_t stat_o;
   logic sys_tick_o;
   logic sys_fast_o;
   logic timer_tick_o;
   // Score counters
   int mismatches = 0;
   int cmp_count = 0;

   // 25 MHz clock
   always #20 clock_i = ~clock_i;

   twin_oscillator_clock_control dut (
      .clock_i(clock_i), .rst_n_i(rst_n_i),
      .fast_osc_on_we_i(fast_osc_on_we_i), .fast_osc_on_i(fast_osc_on_i),
      .slow_osc_on_we_i(slow_osc_on_we_i), .slow_osc_on_i(slow_osc_on_i),
      .sys_sel_we_i(sys_sel_we_i), .sys_sel_fast_i(sys_sel_fast_i),
      .sleep_instruction_i(sleep_instruction_i), .wake_i(wake_i),
      .wdt_enable_i(wdt_enable_i), .fast_osc_tick_i(fast_osc_tick_i),
      .slow_osc_tick_i(slow_osc_tick_i), .ctl_o(ctl_o), .stat_o(stat_o),
      .sys_tick_o(sys_tick_o), .sys_fast_o(sys_fast_o), .timer_tick_o(timer_tick_o));

   // Verdict, reached from the main sequence, a stall or a source change that never came
   task automatic tally_and_finish;
      $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : tally_and_finish

   // Land just after the edge so all updates have settled
   task automatic step(input int n);
      repeat (n) begin
         @(posedge clock_i);
         #1;
      end
   endtask : step

   task automatic chk(input logic got, input logic exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: %s", $time, what);
      end
   endtask : chk

   // One-cycle strobes; each ends one edge later, so no double drive
   task automatic wr_fast(input logic v);
      fast_osc_on_we_i = 1'h1;
      fast_osc_on_i = v;
      step(1);
      fast_osc_on_we_i = 1'h0;
   endtask : wr_fast

   task automatic wr_slow(input logic v);
      slow_osc_on_we_i = 1'h1;
      slow_osc_on_i = v;
      step(1);
      slow_osc_on_we_i = 1'h0;
   endtask : wr_slow

   task automatic wr_sel(input logic v);
      sys_sel_we_i = 1'h1;
      sys_sel_fast_i = v;
      step(1);
      sys_sel_we_i = 1'h0;
   endtask : wr_sel

   task automatic tick(input logic fast);
      if (fast) fast_osc_tick_i = 1'h1;
      else slow_osc_tick_i = 1'h1;
      step(1);
      fast_osc_tick_i = 1'h0;
      slow_osc_tick_i = 1'h0;
   endtask : tick

   // Timer tick seen within three cycles or not
   task automatic seen_timer(input logic exp);
      logic hit;
      hit = 1'h0;
      repeat (3) begin
         if (timer_tick_o === 1'h1) hit = 1'h1;
         step(1);
      end
      chk(hit, exp, "timer tick presence wrong");
   endtask : seen_timer

   // Source change must come with a full tick in the same cycle
   task automatic wait_src(input logic v);
      for (int i = 0; i < 6; i++) begin
         if (sys_fast_o === v) break;
         step(1);
      end
      chk(sys_fast_o, v, "source never changed");
      chk(sys_tick_o, 1'h1, "no tick at changeover");
      if (sys_fast_o !== v) tally_and_finish();
   endtask : wait_src

   initial begin
      #400000;
      mismatches++;
      $display("Error at %0t: run stalled", $time);
      tally_and_finish();
   end

   // Reset state: fast source, both on
   task automatic test_reset;
      repeat (5) @(posedge clock_i);
      #1 rst_n_i = 1'h1;
      step(1);
      chk(ctl_o.sel_fast & ctl_o.fast_osc_on & ctl_o.slow_osc_on, 1'h1, "reset ctl");
      chk(stat_o.fast_run & stat_o.slow_run & !stat_o.standby, 1'h1, "reset stat");
      chk(sys_fast_o, 1'h1, "reset source");
      $display("test reset done");
   endtask : test_reset

   // Locked oscillators refuse a stop
   task automatic test_locks;
      wr_fast(1'h0);
      step(2);
      chk(ctl_o.fast_osc_on & stat_o.fast_run, 1'h1, "fast stopped in use");
      wdt_enable_i = 1'h1;
      wr_slow(1'h0);
      step(2);
      chk(ctl_o.slow_osc_on & stat_o.slow_run, 1'h1, "slow stopped with wdt");
      wdt_enable_i = 1'h0;
      $display("test locks done");
   endtask : test_locks

   // Slow stop and restart, timer feed while fast runs the CPU
   task automatic test_slow_control;
      wr_slow(1'h0);
      step(2);
      chk(ctl_o.slow_osc_on | stat_o.slow_run, 1'h0, "slow stop ignored");
      tick(1'h0);
      seen_timer(1'h0);
      wr_slow(1'h1);
      step(2);
      chk(stat_o.slow_run, 1'h1, "slow restart");
      // Let the slow oscillator settle before timers or selection use it
      step(5);
      tick(1'h0);
      seen_timer(1'h1);
      $display("test slow control done");
   endtask : test_slow_control

   // Change to slow: old tick passes, then park, then slow takes over
   task automatic test_to_slow;
      wr_sel(1'h0);
      step(1);
      chk(ctl_o.sel_fast, 1'h0, "select readback");
      tick(1'h1);
      step(2);
      chk(sys_fast_o, 1'h1, "switched without slow tick");
      tick(1'h0);
      wait_src(1'h0);
      wr_slow(1'h0);
      step(2);
      chk(ctl_o.slow_osc_on & stat_o.slow_run, 1'h1, "slow stopped in use");
      wr_fast(1'h0);
      step(2);
      chk(ctl_o.fast_osc_on | stat_o.fast_run, 1'h0, "fast stop ignored");
      $display("test to slow done");
   endtask : test_to_slow

   // Sleep stops both, wake restores slow-running state
   task automatic test_sleep;
      sleep_instruction_i = 1'h1;
      step(1);
      sleep_instruction_i = 1'h0;
      step(1);
      chk(stat_o.standby, 1'h1, "no standby");
      chk(stat_o.fast_run | stat_o.slow_run, 1'h0, "runs in sleep");
      tick(1'h0);
      seen_timer(1'h0);
      wake_i = 1'h1;
      step(1);
      wake_i = 1'h0;
      step(1);
      chk(stat_o.standby | stat_o.fast_run, 1'h0, "wake state");
      chk(stat_o.slow_run & !sys_fast_o, 1'h1, "wake source");
      $display("test sleep done");
   endtask : test_sleep

   // Start fast, let it settle, then change back
   task automatic test_to_fast;
      wr_fast(1'h1);
      step(2);
      chk(stat_o.fast_run & ctl_o.fast_osc_on, 1'h1, "fast start");
      step(5);
      wr_sel(1'h1);
      tick(1'h0);
      step(2);
      chk(sys_fast_o, 1'h0, "switched without fast tick");
      tick(1'h1);
      wait_src(1'h1);
      $display("test to fast done");
   endtask : test_to_fast

   // Main sequence; each scenario leaves the state the next one starts from
   initial begin
      test_reset();
      test_locks();
      test_slow_control();
      test_to_slow();
      test_sleep();
      test_to_fast();
      tally_and_finish();
   end
endmodule : twin_oscillator_clock_control_tb
